//--- logic/cpu_exception_sequencer.v
`timescale 1ns/10ps
`default_nettype none
`include "exc_seq_consts.vh"

module cpu_exception_sequencer #(
   parameter N_MODULES = `HALT_MODULES,
   parameter DMA_BIT = `HALT_DMA_BIT,
   parameter IDX_W = 4
) (
   input wire ref_clk,
   input wire reset,
   input wire chip_init_pin_n,
   input wire wdt_overflow,
   input wire instr_done,
   input wire instr_was_flag_op,
   input wire trap_exec,
   input wire [`TRAP_NUM_W-1:0] trap_num,
   input wire [`ADDR_W-1:0] cur_pc,
   input wire [`CCR_W-1:0] condition_flags_register,
   input wire [`ADDR_W-1:0] cur_sp,
   input wire nmi_event,
   input wire [`IRQ_LINES-1:0] irq_req,
   input wire periph_req,
   input wire [`VEC_NUM_W-1:0] periph_vec,
   input wire mem_ack,
   input wire [31:0] mem_rdata,
   input wire halt_wr,
   input wire [N_MODULES-1:0] halt_wdata,
   input wire acc_req,
   input wire [IDX_W-1:0] acc_module,
   output reg cpu_hold_reg,
   output reg periph_init_reg,
   output reg set_int_mask_reg,
   output reg pc_load_reg,
   output reg [`ADDR_W-1:0] pc_value_reg,
   output reg sp_load_reg,
   output reg [`ADDR_W-1:0] sp_value_reg,
   output reg mem_req_reg,
   output reg mem_we_reg,
   output reg [`ADDR_W-1:0] mem_addr_reg,
   output reg [31:0] mem_wdata_reg,
   output reg int_ack_reg,
   output reg [`VEC_NUM_W-1:0] int_ack_vec_reg,
   output reg wdt_reset_flag_reg,
   output wire [N_MODULES-1:0] module_halt_control_reg,
   output wire acc_grant_reg,
   output wire acc_refused_reg
);

   // ==========================================
   // States
   localparam [2:0] ST_HOLD = 3'b000;
   localparam [2:0] ST_INIT = 3'b001;
   localparam [2:0] ST_RVEC = 3'b010;
   localparam [2:0] ST_RUN = 3'b011;
   localparam [2:0] ST_PUSH = 3'b100;
   localparam [2:0] ST_VEC = 3'b101;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg nmi_pend_reg;
   reg trap_pend_reg;
   reg [`TRAP_NUM_W-1:0] trap_num_reg;
   reg exc_done_reg;
   reg [`VEC_NUM_W-1:0] vec_reg;
   reg vec_is_int_reg;

   wire boundary;
   wire int_ok;
   wire sel_valid;
   wire sel_is_int;
   wire [`VEC_NUM_W-1:0] sel_vec;
   wire take;
   wire reset_cause;

   // Byte address of a vector table entry
   function [`ADDR_W-1:0] vector_address;
      input [`VEC_NUM_W-1:0] vec;
      begin
         vector_address = {{(`ADDR_W-`VEC_NUM_W-2){1'b0}}, vec, 2'b00};
      end
   endfunction

   // ==========================================
   // Acceptance points
   assign reset_cause = reset || !chip_init_pin_n || wdt_overflow;
   assign boundary = (state_reg == ST_RUN) && (instr_done || exc_done_reg);
   // No sampling after flag ops; reset vector load never raises exc_done
   assign int_ok = boundary && !(instr_done && instr_was_flag_op);
   assign take = boundary && sel_valid && !trap_exec;

   exception_arbiter u_arbiter (
      .int_ok(int_ok),
      .int_mask(condition_flags_register[`CCR_I_BIT]),
      .nmi_pend(nmi_pend_reg),
      .irq_req(irq_req),
      .periph_req(periph_req),
      .periph_vec(periph_vec),
      .trap_pend(trap_pend_reg && boundary),
      .trap_num(trap_num_reg),
      .sel_valid(sel_valid),
      .sel_is_int(sel_is_int),
      .sel_vec(sel_vec)
   );

   module_halt_gate #(
      .N_MODULES(N_MODULES),
      .DMA_BIT(DMA_BIT),
      .IDX_W(IDX_W)
   ) u_halt_gate (
      .ref_clk(ref_clk),
      .reset(reset),
      .periph_init(periph_init_reg),
      .halt_wr(halt_wr && !cpu_hold_reg),
      .halt_wdata(halt_wdata),
      .acc_req(acc_req && !cpu_hold_reg),
      .acc_module(acc_module),
      .module_halt_control_reg(module_halt_control_reg),
      .acc_grant_reg(acc_grant_reg),
      .acc_refused_reg(acc_refused_reg)
   );

   // ==========================================
   // Next state
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_HOLD: begin
            if (chip_init_pin_n && !reset) begin
               state_next = ST_INIT;
            end
         end
         ST_INIT: begin
            state_next = ST_RVEC;
         end
         ST_RVEC: begin
            if (mem_ack) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (take) begin
               state_next = ST_PUSH;
            end
         end
         ST_PUSH: begin
            if (mem_ack) begin
               state_next = ST_VEC;
            end
         end
         ST_VEC: begin
            if (mem_ack) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_HOLD;
         end
      endcase
      if (reset || !chip_init_pin_n) begin
         state_next = ST_HOLD;
      end else if (wdt_overflow) begin
         state_next = ST_INIT;
      end
   end

   always @(posedge ref_clk) begin
      state_reg <= state_next;
   end

   // ==========================================
   // Pending requests: a new event wins over the clear
   always @(posedge ref_clk) begin
      if (reset_cause) begin
         nmi_pend_reg <= 1'b0;
      end else if (nmi_event) begin
         nmi_pend_reg <= 1'b1;
      end else if (take && sel_vec == `VEC_NMI) begin
         nmi_pend_reg <= 1'b0;
      end
   end

   always @(posedge ref_clk) begin
      if (reset_cause) begin
         trap_pend_reg <= 1'b0;
         trap_num_reg <= {`TRAP_NUM_W{1'b0}};
      end else if (trap_exec && state_reg == ST_RUN) begin
         trap_pend_reg <= 1'b1;
         trap_num_reg <= trap_num;
      end else if (take && !sel_is_int) begin
         trap_pend_reg <= 1'b0;
      end
   end

   // ==========================================
   // Sequencing outputs
   always @(posedge ref_clk) begin
      if (reset_cause) begin
         cpu_hold_reg <= 1'b1;
         periph_init_reg <= 1'b1;
         set_int_mask_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         pc_value_reg <= {`ADDR_W{1'b0}};
         sp_load_reg <= 1'b0;
         sp_value_reg <= {`ADDR_W{1'b0}};
         mem_req_reg <= 1'b0;
         mem_we_reg <= 1'b0;
         mem_addr_reg <= {`ADDR_W{1'b0}};
         mem_wdata_reg <= 32'h00000000;
         int_ack_reg <= 1'b0;
         int_ack_vec_reg <= `VEC_RESET;
         exc_done_reg <= 1'b0;
         vec_reg <= `VEC_RESET;
         vec_is_int_reg <= 1'b0;
      end else begin
         pc_load_reg <= 1'b0;
         sp_load_reg <= 1'b0;
         set_int_mask_reg <= 1'b0;
         int_ack_reg <= 1'b0;
         periph_init_reg <= 1'b0;
         case (state_reg)
            ST_HOLD: begin
               cpu_hold_reg <= 1'b1;
               periph_init_reg <= 1'b1;
            end
            ST_INIT: begin
               // Step one: clear state, raise the mask, fetch entry zero next
               periph_init_reg <= 1'b1;
               set_int_mask_reg <= 1'b1;
               exc_done_reg <= 1'b0;
               mem_req_reg <= 1'b1;
               mem_we_reg <= 1'b0;
               mem_addr_reg <= vector_address(`VEC_RESET);
            end
            ST_RVEC: begin
               if (mem_ack) begin
                  mem_req_reg <= 1'b0;
                  pc_load_reg <= 1'b1;
                  pc_value_reg <= mem_rdata[`ADDR_W-1:0];
                  cpu_hold_reg <= 1'b0;
               end
            end
            ST_RUN: begin
               exc_done_reg <= 1'b0;
               if (take) begin
                  cpu_hold_reg <= 1'b1;
                  vec_reg <= sel_vec;
                  vec_is_int_reg <= sel_is_int;
                  int_ack_reg <= sel_is_int && sel_vec != `VEC_NMI;
                  int_ack_vec_reg <= sel_vec;
                  // Flags in the top byte, counter below, one long word
                  mem_req_reg <= 1'b1;
                  mem_we_reg <= 1'b1;
                  mem_addr_reg <= cur_sp - `STACK_WORD_BYTES;
                  mem_wdata_reg <= {condition_flags_register, cur_pc};
               end
            end
            ST_PUSH: begin
               if (mem_ack) begin
                  sp_load_reg <= 1'b1;
                  sp_value_reg <= mem_addr_reg;
                  mem_we_reg <= 1'b0;
                  mem_addr_reg <= vector_address(vec_reg);
               end
            end
            ST_VEC: begin
               if (mem_ack) begin
                  mem_req_reg <= 1'b0;
                  pc_load_reg <= 1'b1;
                  pc_value_reg <= mem_rdata[`ADDR_W-1:0];
                  set_int_mask_reg <= 1'b1;
                  cpu_hold_reg <= 1'b0;
                  exc_done_reg <= 1'b1;
               end
            end
            default: begin
               cpu_hold_reg <= 1'b1;
               mem_req_reg <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================
   // Reset source indication, kept across a watchdog reset
   always @(posedge ref_clk) begin
      if (reset || !chip_init_pin_n) begin
         wdt_reset_flag_reg <= 1'b0;
      end else if (wdt_overflow) begin
         wdt_reset_flag_reg <= 1'b1;
      end
   end

endmodule

`default_nettype wire

//--- logic/exc_seq_consts.vh
`ifndef EXC_SEQ_CONSTS_VH
`define EXC_SEQ_CONSTS_VH

// ==========================================
// Vector numbers
`define VEC_NUM_W 7
`define VEC_RESET 7'h00
`define VEC_NMI 7'h07
`define VEC_TRAP_BASE 7'h08
`define VEC_IRQ_BASE 7'h10
`define VEC_PERIPH_FIRST 7'h18
`define VEC_PERIPH_LAST 7'h6E

// ==========================================
// Widths and field positions
`define ADDR_W 24
`define CCR_W 8
`define CCR_I_BIT 7
`define IRQ_LINES 8
`define TRAP_NUM_W 2
`define STACK_WORD_BYTES 24'h000004

// ==========================================
// Module halt control reset values
`define HALT_MODULES 16
`define HALT_DMA_BIT 13
`define HALT_RESET_ALL 16'hFFFF

// ==========================================
// External reset hold times (kept by the reset source)
`define RESET_HOLD_POWERON_MS 20
`define RESET_HOLD_RUN_STATES 20

`endif

//--- logic/exception_arbiter.v
`timescale 1ns/10ps
`default_nettype none
`include "exc_seq_consts.vh"

module exception_arbiter (
   input wire int_ok,
   input wire int_mask,
   input wire nmi_pend,
   input wire [`IRQ_LINES-1:0] irq_req,
   input wire periph_req,
   input wire [`VEC_NUM_W-1:0] periph_vec,
   input wire trap_pend,
   input wire [`TRAP_NUM_W-1:0] trap_num,
   output reg sel_valid,
   output reg sel_is_int,
   output reg [`VEC_NUM_W-1:0] sel_vec
);

   integer i;
   reg irq_found;
   reg [`VEC_NUM_W-1:0] irq_vec;
   wire periph_in_range;

   // Reserved vector numbers are never produced
   assign periph_in_range = (periph_vec >= `VEC_PERIPH_FIRST) &&
                            (periph_vec <= `VEC_PERIPH_LAST);

   always @* begin
      irq_found = 1'b0;
      irq_vec = `VEC_IRQ_BASE;
      for (i = `IRQ_LINES - 1; i >= 0; i = i - 1) begin
         if (irq_req[i]) begin
            irq_found = 1'b1;
            irq_vec = `VEC_IRQ_BASE + i[`VEC_NUM_W-1:0];
         end
      end
   end

   // Fixed ranking: interrupts over trap, NMI over every other interrupt
   always @* begin
      sel_valid = 1'b0;
      sel_is_int = 1'b0;
      sel_vec = `VEC_RESET;
      if (int_ok && nmi_pend) begin
         sel_valid = 1'b1;
         sel_is_int = 1'b1;
         sel_vec = `VEC_NMI;
      end else if (int_ok && !int_mask && irq_found) begin
         sel_valid = 1'b1;
         sel_is_int = 1'b1;
         sel_vec = irq_vec;
      end else if (int_ok && !int_mask && periph_req && periph_in_range) begin
         sel_valid = 1'b1;
         sel_is_int = 1'b1;
         sel_vec = periph_vec;
      end else if (trap_pend) begin
         sel_valid = 1'b1;
         sel_vec = `VEC_TRAP_BASE + {{(`VEC_NUM_W-`TRAP_NUM_W){1'b0}}, trap_num};
      end
   end

endmodule

`default_nettype wire

//--- logic/module_halt_gate.v
`timescale 1ns/10ps
`default_nettype none
`include "exc_seq_consts.vh"

module module_halt_gate #(
   parameter N_MODULES = `HALT_MODULES,
   parameter DMA_BIT = `HALT_DMA_BIT,
   parameter IDX_W = 4
) (
   input wire ref_clk,
   input wire reset,
   input wire periph_init,
   input wire halt_wr,
   input wire [N_MODULES-1:0] halt_wdata,
   input wire acc_req,
   input wire [IDX_W-1:0] acc_module,
   output reg [N_MODULES-1:0] module_halt_control_reg,
   output reg acc_grant_reg,
   output reg acc_refused_reg
);

   localparam [N_MODULES-1:0] HALT_RESET_VALUE =
      `HALT_RESET_ALL & ~({{(N_MODULES-1){1'b0}}, 1'b1} << DMA_BIT);

   wire halted;

   assign halted = module_halt_control_reg[acc_module];

   // ==========================================
   // Halt register: all modules stopped except the DMA controller on reset or peripheral init, then loaded from halt_wdata
   always @(posedge ref_clk) begin
      if (reset || periph_init) begin
         module_halt_control_reg <= HALT_RESET_VALUE;
      end else if (halt_wr) begin
         module_halt_control_reg <= halt_wdata;
      end
   end

   // ==========================================
   // Access gate for peripheral registers
   always @(posedge ref_clk) begin
      if (reset || periph_init) begin
         acc_grant_reg <= 1'b0;
         acc_refused_reg <= 1'b0;
      end else begin
         acc_grant_reg <= acc_req && !halted;
         acc_refused_reg <= acc_req && halted;
      end
   end

endmodule

`default_nettype wire

//--- verif/exc_seq_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "exc_seq_consts.vh"
module exc_seq_monitor #(
   parameter N_MODULES = `HALT_MODULES,
   parameter DMA_BIT = `HALT_DMA_BIT,
   parameter IDX_W = 4
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic chip_init_pin_n,
   input wire logic [`ADDR_W-1:0] cur_pc,
   input wire logic [`ADDR_W-1:0] cur_sp,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic acc_req,
   input wire logic [IDX_W-1:0] acc_module,
   input wire logic cpu_hold_reg,
   input wire logic set_int_mask_reg,
   input wire logic pc_load_reg,
   input wire logic [`ADDR_W-1:0] pc_value_reg,
   input wire logic sp_load_reg,
   input wire logic [`ADDR_W-1:0] sp_value_reg,
   input wire logic mem_req_reg,
   input wire logic mem_we_reg,
   input wire logic [`ADDR_W-1:0] mem_addr_reg,
   input wire logic [31:0] mem_wdata_reg,
   input wire logic int_ack_reg,
   input wire logic [`VEC_NUM_W-1:0] int_ack_vec_reg,
   input wire logic [N_MODULES-1:0] module_halt_control_reg,
   input wire logic acc_grant_reg,
   input wire logic acc_refused_reg
);
   // ==========
   // Helpers and checks
   logic [`ADDR_W-1:0] rdata_q;
   logic halted_q;
   always @(posedge ref_clk) begin
      rdata_q <= mem_rdata[`ADDR_W-1:0];
      halted_q <= module_halt_control_reg[acc_module];
   end
   default clocking cb @(posedge ref_clk); endclocking
   rst_hold_a: assert property (reset |=> cpu_hold_reg && !mem_req_reg)
      else $error("hold missing after reset");
   halt_init_a: assert property (reset |=> module_halt_control_reg == N_MODULES'(~(1 << DMA_BIT)))
      else $error("halt register reset value wrong");
   pin_hold_a: assert property (disable iff (reset) !chip_init_pin_n |=> cpu_hold_reg)
      else $error("running while pin low");
   vec_addr_a: assert property (disable iff (reset) mem_req_reg && !mem_we_reg |->
      mem_addr_reg[1:0] == 2'b00 && mem_addr_reg <= 24'h1B8 &&
      !(mem_addr_reg inside {[24'h4:24'h18], [24'h30:24'h3C]}))
      else $error("bad vector address");
   ack_vec_a: assert property (disable iff (reset) int_ack_reg |->
      int_ack_vec_reg >= 16 && int_ack_vec_reg <= 110)
      else $error("bad acknowledged vector");
   push_first_a: assert property (disable iff (reset) $rose(mem_req_reg) && mem_we_reg |->
      mem_addr_reg == cur_sp - 24'h4 && mem_wdata_reg[23:0] == cur_pc)
      else $error("bad context push");
   reset_read_a: assert property (disable iff (reset) $rose(mem_req_reg) && !mem_we_reg |->
      mem_addr_reg == 24'h0 && set_int_mask_reg)
      else $error("bad reset vector read");
   order_a: assert property (disable iff (reset) mem_req_reg && mem_we_reg && mem_ack |=>
      mem_req_reg && !mem_we_reg && sp_load_reg && sp_value_reg == $past(mem_addr_reg))
      else $error("vector read does not follow push");
   end_seq_a: assert property (disable iff (reset) mem_req_reg && !mem_we_reg && mem_ack |=>
      pc_load_reg && pc_value_reg == rdata_q && !mem_req_reg)
      else $error("counter not loaded from vector");
   grant_a: assert property (disable iff (reset) acc_req |=>
      acc_refused_reg == halted_q && acc_grant_reg == !halted_q)
      else $error("access answer wrong");
endmodule
`default_nettype wire

//--- verif/exc_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module exc_mem_model (
   input wire logic ref_clk,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [23:0] mem_addr,
   input wire logic [2:0] lat,
   output wire logic mem_ack,
   output wire logic [31:0] mem_rdata
);
   // ==========
   // Vector table memory, toggling data when idle
   int cnt = 0;
   logic ack_q = 1'b0;
   logic [31:0] rdata_q = 32'h0;
   assign mem_ack = ack_q;
   assign mem_rdata = rdata_q;
   always @(posedge ref_clk) begin
      ack_q <= 1'b0;
      rdata_q <= ~rdata_q;
      if (mem_req && !ack_q) begin
         if (cnt >= lat) begin
            cnt <= 0;
            ack_q <= 1'b1;
            if (!mem_we)
               rdata_q <= {8'h00, mem_addr ^ 24'hABC000};
         end else
            cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

//--- verif/cpu_exception_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "exc_seq_consts.vh"
module cpu_exception_sequencer_tb;
   // ==========
   // Stimulus, design and partner
   logic ref_clk = 0, reset = 1, chip_init_pin_n = 1, wdt_overflow = 0, instr_done = 0;
   logic instr_was_flag_op = 0, trap_exec = 0, nmi_event = 0, periph_req = 0;
   logic halt_wr = 0, acc_req = 0, mem_ack;
   logic [1:0] trap_num = 0;
   logic [23:0] cur_pc = 24'h012340, cur_sp = 24'hFFE000;
   logic [7:0] condition_flags_register = 0, irq_req = 0;
   logic [6:0] periph_vec = 0;
   logic [15:0] halt_wdata = 0;
   logic [3:0] acc_module = 0;
   logic [2:0] lat = 0;
   logic [31:0] mem_rdata, mem_wdata_reg;
   logic cpu_hold_reg, periph_init_reg, set_int_mask_reg, pc_load_reg, sp_load_reg;
   logic mem_req_reg, mem_we_reg, int_ack_reg, wdt_reset_flag_reg;
   logic acc_grant_reg, acc_refused_reg;
   logic [23:0] pc_value_reg, sp_value_reg, mem_addr_reg;
   logic [6:0] int_ack_vec_reg;
   logic [15:0] module_halt_control_reg;
   int failures = 0, n_compared = 0, seed = 30852, p_nmi = 0, p_irq = 0, p_per = 0;
   int p_trap = -1, m, d;
   always #2 ref_clk = ~ref_clk;
   cpu_exception_sequencer u_dut (.ref_clk(ref_clk), .reset(reset),
      .chip_init_pin_n(chip_init_pin_n), .wdt_overflow(wdt_overflow),
      .instr_done(instr_done), .instr_was_flag_op(instr_was_flag_op),
      .trap_exec(trap_exec), .trap_num(trap_num), .cur_pc(cur_pc),
      .condition_flags_register(condition_flags_register), .cur_sp(cur_sp),
      .nmi_event(nmi_event), .irq_req(irq_req), .periph_req(periph_req),
      .periph_vec(periph_vec), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .halt_wr(halt_wr), .halt_wdata(halt_wdata), .acc_req(acc_req),
      .acc_module(acc_module), .cpu_hold_reg(cpu_hold_reg),
      .periph_init_reg(periph_init_reg), .set_int_mask_reg(set_int_mask_reg),
      .pc_load_reg(pc_load_reg), .pc_value_reg(pc_value_reg),
      .sp_load_reg(sp_load_reg), .sp_value_reg(sp_value_reg),
      .mem_req_reg(mem_req_reg), .mem_we_reg(mem_we_reg), .mem_addr_reg(mem_addr_reg),
      .mem_wdata_reg(mem_wdata_reg), .int_ack_reg(int_ack_reg),
      .int_ack_vec_reg(int_ack_vec_reg), .wdt_reset_flag_reg(wdt_reset_flag_reg),
      .module_halt_control_reg(module_halt_control_reg),
      .acc_grant_reg(acc_grant_reg), .acc_refused_reg(acc_refused_reg));
   exc_mem_model u_mem (.ref_clk(ref_clk), .mem_req(mem_req_reg), .mem_we(mem_we_reg),
      .mem_addr(mem_addr_reg), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // ==========
   // Tasks and bench model
   task automatic tick(input int n = 1);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic ready(input int k);
      if (k == 0)
         return mem_req_reg && mem_we_reg;
      if (k == 1)
         return mem_req_reg && !mem_we_reg;
      return pc_load_reg;
   endfunction
   task automatic wait_for(input int k);
      int i;
      for (i = 0; i < 60 && ready(k) !== 1'b1; i++)
         tick();
      cmp(i < 60, 1);
   endtask
   function automatic int pick();
      int k;
      if (p_nmi)
         return 7;
      for (k = 0; k < 8; k++)
         if (p_irq[k] && !condition_flags_register[7])
            return 16 + k;
      if (p_per && !condition_flags_register[7])
         return p_per;
      return 8 + p_trap;
   endfunction
   task automatic serve();
      int v;
      v = pick();
      lat = 3'($random(seed) & 3);
      wait_for(0);
      cmp(mem_addr_reg, cur_sp - 4);
      cmp(mem_wdata_reg, {condition_flags_register, cur_pc});
      cmp(int_ack_reg, v >= 16);
      if (v >= 16)
         cmp(int_ack_vec_reg, v);
      if (v == 7)
         p_nmi = 0;
      else if (v < 16)
         p_trap = -1;
      else if (v < 24) begin
         p_irq[v - 16] = 0;
         irq_req[v - 16] = 0;
      end else begin
         p_per = 0;
         periph_req = 0;
      end
      wait_for(1);
      cmp({sp_load_reg, sp_value_reg}, {1'b1, cur_sp - 24'h4});
      cmp(mem_addr_reg, v * 4);
      wait_for(2);
      cmp(pc_value_reg, (v * 4) ^ 24'hABC000);
      cmp({set_int_mask_reg, cpu_hold_reg}, 2'b10);
      condition_flags_register[7] = 1;
      tick(2);
   endtask
   task automatic expect_reset();
      wait_for(1);
      cmp({set_int_mask_reg, periph_init_reg, mem_addr_reg}, 26'h3000000);
      condition_flags_register[7] = 1;
      wait_for(2);
      cmp({periph_init_reg, pc_value_reg}, 25'h0ABC000);
      cmp(module_halt_control_reg, 16'hFFFF ^ (16'h1 << 13));
   endtask
   task automatic step(input bit flag_op, input bit trap);
      instr_done = 1;
      instr_was_flag_op = flag_op;
      trap_exec = trap;
      trap_num = 2'($random(seed));
      if (trap)
         p_trap = trap_num;
      tick();
      {instr_done, instr_was_flag_op, trap_exec} = 0;
   endtask
   task automatic post(input bit nmi, input logic [7:0] irq, input int per);
      nmi_event = nmi;
      p_nmi |= nmi;
      irq_req |= irq;
      p_irq |= irq;
      periph_req = per != 0;
      periph_vec = 7'(per);
      p_per = per;
      tick();
      nmi_event = 0;
   endtask
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ==========
   // Scenarios
   initial begin
      tick(5);
      reset = 0;
      expect_reset();
      post(1, 8'h01, 0);
      tick(5);
      cmp(cpu_hold_reg, 0);
      cur_sp = 24'hFFF000;
      step(0, 0);
      serve();
      $display("test reset done");
      cur_pc = 24'($random(seed));
      post(1, 8'h28, 24 + {$random(seed)} % 87);
      repeat (5) begin
         condition_flags_register[7] = 0;
         step(0, 0);
         serve();
      end
      $display("test priority done");
      post(0, 8'h04, 0);
      condition_flags_register[7] = 0;
      step(1, 0);
      tick(8);
      cmp(cpu_hold_reg, 0);
      step(0, 0);
      serve();
      $display("test flag op done");
      post(0, 8'h02, 0);
      step(0, 1);
      tick();
      step(0, 0);
      serve();
      condition_flags_register[7] = 0;
      step(0, 1);
      tick();
      step(0, 0);
      serve();
      serve();
      $display("test trap done");
      wdt_overflow = 1;
      tick();
      wdt_overflow = 0;
      expect_reset();
      cmp(wdt_reset_flag_reg, 1);
      chip_init_pin_n = 0;
      repeat (20) begin
         tick();
         cmp({cpu_hold_reg, pc_load_reg}, 2'b10);
      end
      chip_init_pin_n = 1;
      expect_reset();
      cmp(wdt_reset_flag_reg, 0);
      $display("test resets done");
      acc_req = 1;
      for (m = 0; m < 16; m++) begin
         acc_module = 4'(m);
         tick();
         cmp({acc_refused_reg, acc_grant_reg}, (m == 13) ? 2'b01 : 2'b10);
      end
      acc_req = 0;
      halt_wr = 1;
      halt_wdata = 16'($random(seed));
      tick();
      halt_wr = 0;
      cmp(module_halt_control_reg, halt_wdata);
      acc_req = 1;
      acc_module = 4'($random(seed));
      d = halt_wdata[acc_module];
      tick();
      acc_req = 0;
      cmp({acc_refused_reg, acc_grant_reg}, d ? 2'b10 : 2'b01);
      $display("test module halt done");
      end_sim();
   end
   // Whole run is a few hundred cycles, far below the 10000-cycle limit
   initial begin
      #40000;
      failures++;
      end_sim();
   end
endmodule
bind cpu_exception_sequencer exc_seq_monitor #(.N_MODULES(N_MODULES), .DMA_BIT(DMA_BIT),
   .IDX_W(IDX_W)) u_mon (.ref_clk(ref_clk), .reset(reset),
   .chip_init_pin_n(chip_init_pin_n), .cur_pc(cur_pc), .cur_sp(cur_sp),
   .mem_ack(mem_ack), .mem_rdata(mem_rdata), .acc_req(acc_req), .acc_module(acc_module),
   .cpu_hold_reg(cpu_hold_reg), .set_int_mask_reg(set_int_mask_reg),
   .pc_load_reg(pc_load_reg), .pc_value_reg(pc_value_reg), .sp_load_reg(sp_load_reg),
   .sp_value_reg(sp_value_reg), .mem_req_reg(mem_req_reg), .mem_we_reg(mem_we_reg),
   .mem_addr_reg(mem_addr_reg), .mem_wdata_reg(mem_wdata_reg),
   .int_ack_reg(int_ack_reg), .int_ack_vec_reg(int_ack_vec_reg),
   .module_halt_control_reg(module_halt_control_reg),
   .acc_grant_reg(acc_grant_reg), .acc_refused_reg(acc_refused_reg));
`default_nettype wire
